// file: hw/pfcs_defines.vh
`ifndef PFCS_DEFINES_VH
`define PFCS_DEFINES_VH

// command sequence addresses and data
`define PFCS_ADDR_UNLOCK1   16'h5555
`define PFCS_ADDR_UNLOCK2   16'h2AAA
`define PFCS_DATA_UNLOCK1   8'hAA
`define PFCS_DATA_UNLOCK2   8'h55
`define PFCS_CMD_PROGRAM    8'hA0
`define PFCS_CMD_ERASE_SET  8'h80
`define PFCS_CMD_SECTOR     8'h30
`define PFCS_CMD_CHIP       8'h10
`define PFCS_CMD_RESET      8'hF0
`define PFCS_CMD_IDENT      8'h90
`define PFCS_ADDR_MFR_ID    16'h0000
`define PFCS_ADDR_DEV_ID    16'h0001

// host operation codes
`define PFCS_OP_READ        3'h0
`define PFCS_OP_PROGRAM     3'h1
`define PFCS_OP_SECTOR      3'h2
`define PFCS_OP_CHIP        3'h3
`define PFCS_OP_RESET       3'h4
`define PFCS_OP_RESET_LONG  3'h5
`define PFCS_OP_IDENT       3'h6

// bus phase lengths in clocks of 40 ns
`define PFCS_CLK_NS         40
`define PFCS_SETUP_CYC      2'h1
`define PFCS_STROBE_NS      90
`define PFCS_STROBE_CYC     ((`PFCS_STROBE_NS + `PFCS_CLK_NS - 1) / `PFCS_CLK_NS)
`define PFCS_RECOVER_CYC    2
`define PFCS_READ_NS        90
`define PFCS_READ_CYC       ((`PFCS_READ_NS + `PFCS_CLK_NS - 1) / `PFCS_CLK_NS + 1)

// self-timed operation waits
`define PFCS_PROG_US        30
`define PFCS_PROG_CYC       ((`PFCS_PROG_US * 1000 + `PFCS_CLK_NS - 1) / `PFCS_CLK_NS)
`define PFCS_SECTOR_MS      10
`define PFCS_SECTOR_CYC     ((`PFCS_SECTOR_MS * 1000000 + `PFCS_CLK_NS - 1) / `PFCS_CLK_NS)
`define PFCS_CHIP_MS        500
`define PFCS_CHIP_CYC       ((`PFCS_CHIP_MS * 1000000 + `PFCS_CLK_NS - 1) / `PFCS_CLK_NS)

`endif

// file: hw/pfcs_sync.v
`timescale 1ns/1ps

// three-stage input synchroniser; output changes when stages two and three agree
module pfcs_sync #(
	parameter W = 8
) (
	input  wire         clk,
	input  wire         rst,
	input  wire [W-1:0] din,
	output reg  [W-1:0] dout
);
	reg [W-1:0] s1_r;
	reg [W-1:0] s2_r;
	reg [W-1:0] s3_r;

	always @(posedge clk)
	begin
		if (rst)
		begin
			s1_r <= {W{1'b0}};
			s2_r <= {W{1'b0}};
			s3_r <= {W{1'b0}};
			dout <= {W{1'b0}};
		end
		else
		begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r)
				dout <= s3_r;
		end
	end
endmodule // pfcs_sync

// file: hw/pfcs_host.v
`timescale 1ns/1ps
`include "pfcs_defines.vh"

module pfcs_host #(
	parameter PROG_CYC   = `PFCS_PROG_CYC,
	parameter SECTOR_CYC = `PFCS_SECTOR_CYC,
	parameter CHIP_CYC   = `PFCS_CHIP_CYC
) (
	input  wire        clk,
	input  wire        rst,
	input  wire        req_valid,
	input  wire [2:0]  req_op,
	input  wire [15:0] req_addr,
	input  wire [7:0]  req_data,
	output reg         req_ready,
	output reg         rsp_valid,
	output reg  [7:0]  rsp_data,
	output reg  [7:0]  rsp_data2,
	output reg  [15:0] flash_addr,
	output reg         flash_ce_n,
	output reg         flash_oe_n,
	output reg         flash_we_n,
	output reg  [7:0]  flash_dq_o,
	output reg         flash_dq_oe,
	input  wire [7:0]  flash_dq_i
);
	localparam ST_IDLE  = 3'h0;
	localparam ST_SETUP = 3'h1;
	localparam ST_WRITE = 3'h2;
	localparam ST_REC   = 3'h3;
	localparam ST_READ  = 3'h4;
	localparam ST_WAIT  = 3'h5;
	localparam ST_DONE  = 3'h6;

	reg  [2:0]  state_r;
	reg  [2:0]  op_r;
	reg  [15:0] addr_r;
	reg  [7:0]  data_r;
	reg  [2:0]  step_r;
	reg  [24:0] cnt_r;
	reg         second_r;
	wire [7:0]  dq_sync;

	pfcs_sync #(.W(8)) pfcs_sync_i (
		.clk  (clk),
		.rst  (rst),
		.din  (flash_dq_i),
		.dout (dq_sync)
	);

	// number of bus write cycles per op
	function [2:0] seq_len;
		input [2:0] op;
		begin
			case (op)
				`PFCS_OP_PROGRAM:    seq_len = 3'h4;
				`PFCS_OP_SECTOR:     seq_len = 3'h6;
				`PFCS_OP_CHIP:       seq_len = 3'h6;
				`PFCS_OP_RESET:      seq_len = 3'h1;
				`PFCS_OP_RESET_LONG: seq_len = 3'h3;
				`PFCS_OP_IDENT:      seq_len = 3'h3;
				default:             seq_len = 3'h0;
			endcase
		end
	endfunction

	// address/data of write cycle number s of op
	reg [15:0] cyc_addr;
	reg [7:0]  cyc_data;
	always @*
	begin
		cyc_addr = `PFCS_ADDR_UNLOCK1;
		cyc_data = `PFCS_DATA_UNLOCK1;
		if (op_r == `PFCS_OP_RESET)
		begin
			cyc_addr = addr_r;
			cyc_data = `PFCS_CMD_RESET;
		end
		else
		begin
			case (step_r)
				3'h1, 3'h4:
				begin
					cyc_addr = `PFCS_ADDR_UNLOCK2;
					cyc_data = `PFCS_DATA_UNLOCK2;
				end
				3'h2:
				begin
					case (op_r)
						`PFCS_OP_PROGRAM:    cyc_data = `PFCS_CMD_PROGRAM;
						`PFCS_OP_RESET_LONG: cyc_data = `PFCS_CMD_RESET;
						`PFCS_OP_IDENT:      cyc_data = `PFCS_CMD_IDENT;
						default:             cyc_data = `PFCS_CMD_ERASE_SET;
					endcase
				end
				3'h3:
				begin
					if (op_r == `PFCS_OP_PROGRAM)
					begin
						cyc_addr = addr_r;
						cyc_data = data_r;
					end
				end
				3'h5:
				begin
					if (op_r == `PFCS_OP_SECTOR)
					begin
						cyc_addr = addr_r;
						cyc_data = `PFCS_CMD_SECTOR;
					end
					else
						cyc_data = `PFCS_CMD_CHIP;
				end
				default:
				begin
					cyc_addr = `PFCS_ADDR_UNLOCK1;
					cyc_data = `PFCS_DATA_UNLOCK1;
				end
			endcase
		end
	end

	always @(posedge clk)
	begin
		if (rst)
		begin
			state_r     <= ST_IDLE;
			op_r        <= 3'h0;
			addr_r      <= 16'h0000;
			data_r      <= 8'h00;
			step_r      <= 3'h0;
			cnt_r       <= 25'h0000000;
			second_r    <= 1'b0;
			req_ready   <= 1'b0;
			rsp_valid   <= 1'b0;
			rsp_data    <= 8'h00;
			rsp_data2   <= 8'h00;
			flash_addr  <= 16'h0000;
			flash_ce_n  <= 1'b1;
			flash_oe_n  <= 1'b1;
			flash_we_n  <= 1'b1;
			flash_dq_o  <= 8'h00;
			flash_dq_oe <= 1'b0;
		end
		else
		begin
			rsp_valid <= 1'b0;
			case (state_r)
				ST_IDLE:
				begin
					flash_ce_n  <= 1'b1;
					flash_oe_n  <= 1'b1;
					flash_we_n  <= 1'b1;
					flash_dq_oe <= 1'b0;
					req_ready   <= 1'b1;
					if (req_valid && req_ready)
					begin
						req_ready <= 1'b0;
						op_r      <= req_op;
						addr_r    <= req_addr;
						data_r    <= req_data;
						step_r    <= 3'h0;
						second_r  <= 1'b0;
						cnt_r     <= 25'h0000000;
						if (req_op == `PFCS_OP_READ)
						begin
							flash_addr <= req_addr;
							state_r    <= ST_READ;
						end
						else if (seq_len(req_op) == 3'h0)
							state_r <= ST_DONE; // unknown op: no bus activity
						else
							state_r <= ST_SETUP;
					end
				end
				ST_SETUP:
				begin
					// address, data and chip select settle before the strobe falls
					flash_addr  <= cyc_addr;
					flash_dq_o  <= cyc_data;
					flash_dq_oe <= 1'b1;
					flash_oe_n  <= 1'b1;
					flash_ce_n  <= 1'b0;
					cnt_r       <= 25'h0000000;
					state_r     <= ST_WRITE;
				end
				ST_WRITE:
				begin
					flash_we_n <= 1'b0;
					cnt_r      <= cnt_r + 25'h0000001;
					if (cnt_r == `PFCS_STROBE_CYC)
					begin
						flash_we_n <= 1'b1;
						cnt_r      <= 25'h0000000;
						state_r    <= ST_REC;
					end
				end
				ST_REC:
				begin
					// data and chip select held past the strobe rise
					cnt_r <= cnt_r + 25'h0000001;
					if (cnt_r == 25'h0000001)
					begin
						flash_ce_n  <= 1'b1;
						flash_dq_oe <= 1'b0;
					end
					if (cnt_r == `PFCS_RECOVER_CYC)
					begin
						cnt_r <= 25'h0000000;
						if (step_r + 3'h1 == seq_len(op_r))
						begin
							if (op_r == `PFCS_OP_IDENT)
							begin
								flash_addr <= `PFCS_ADDR_MFR_ID;
								state_r    <= ST_READ;
							end
							else
								state_r <= ST_WAIT;
						end
						else
						begin
							step_r  <= step_r + 3'h1;
							state_r <= ST_SETUP;
						end
					end
				end
				ST_READ:
				begin
					flash_we_n <= 1'b1;
					flash_ce_n <= 1'b0;
					flash_oe_n <= 1'b0;
					cnt_r      <= cnt_r + 25'h0000001;
					if (cnt_r == `PFCS_READ_CYC + 3)
					begin
						flash_ce_n <= 1'b1;
						flash_oe_n <= 1'b1;
						cnt_r      <= 25'h0000000;
						if (op_r == `PFCS_OP_IDENT && !second_r)
						begin
							rsp_data   <= dq_sync;
							second_r   <= 1'b1;
							flash_addr <= `PFCS_ADDR_DEV_ID;
							state_r    <= ST_WAIT;
						end
						else
						begin
							if (op_r == `PFCS_OP_IDENT)
								rsp_data2 <= dq_sync;
							else
								rsp_data <= dq_sync;
							state_r <= ST_DONE;
						end
					end
				end
				ST_WAIT:
				begin
					// self-timed operation; no bus writes issued meanwhile
					cnt_r <= cnt_r + 25'h0000001;
					if (op_r == `PFCS_OP_IDENT)
						state_r <= ST_READ; // one idle cycle between id reads
					else if ((op_r == `PFCS_OP_PROGRAM && cnt_r >= PROG_CYC) ||
						(op_r == `PFCS_OP_SECTOR && cnt_r >= SECTOR_CYC) ||
						(op_r == `PFCS_OP_CHIP && cnt_r >= CHIP_CYC) ||
						op_r == `PFCS_OP_RESET || op_r == `PFCS_OP_RESET_LONG)
						state_r <= ST_DONE;
					if (op_r == `PFCS_OP_IDENT)
						cnt_r <= 25'h0000000;
				end
				ST_DONE:
				begin
					rsp_valid <= 1'b1;
					state_r   <= ST_IDLE;
				end
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end
endmodule // pfcs_host

// file: verif/pfcs_flash_model.sv
`timescale 1ns/1ps
module pfcs_flash_model #(
	parameter PROG_NS = 400,
	parameter SECT_NS = 1000,
	parameter MFR_ID  = 8'h5A, // arbitrary
	parameter DEV_ID  = 8'hC3  // arbitrary
) (
	input  wire [15:0] addr,
	input  wire        ce_n,
	input  wire        oe_n,
	input  wire        we_n,
	input  wire [7:0]  dq_in,
	output reg  [7:0]  dq_out
);
	reg  [7:0]  mem [0:65535];
	reg  [15:0] a_r;
	reg  [2:0]  st_r = 3'h0;
	reg         id_r = 1'b0;
	realtime    t_r = 1.0e9; // no write is taken before the first real strobe fall
	integer     i;
	integer     s;
	wire        wr_n = ce_n | we_n | !oe_n;
	wire        rd = !ce_n && !oe_n && we_n;
	initial
	begin
		dq_out = 8'h00;
		for (i = 0; i < 65536; i = i + 1)
			mem[i] = 8'hFF;
	end
	task erase(input [6:0] sec);
		for (i = 0; i < 512; i = i + 1)
			mem[{sec, i[8:0]}] = 8'hFF;
	endtask
	task chip;
		for (s = 0; s < 128; s = s + 1)
		begin
			for (i = 0; i < 512; i = i + 1)
				mem[{s[6:0], i[8:0]}] = 8'h00;
			erase(s[6:0]);
			#20;
		end
	endtask
	// a write landing while a task below still waits is lost
	always @(negedge wr_n)
	begin
		a_r = addr;
		t_r = $realtime;
	end
	always @(posedge wr_n)
		if ($realtime - t_r >= 5.0)
			cmd(a_r, dq_in);
	task cmd(input [15:0] a, input [7:0] d);
		if (d == 8'hF0 && st_r != 3'h6)
		begin
			st_r = 3'h0;
			id_r = 1'b0;
		end
		else case (st_r)
		3'h0, 3'h3: st_r = (a == 16'h5555 && d == 8'hAA) ? st_r + 3'h1 : 3'h0;
		3'h1, 3'h4: st_r = (a == 16'h2AAA && d == 8'h55) ? st_r + 3'h1 : 3'h0;
		3'h2:
		begin
			id_r = id_r | (a == 16'h5555 && d == 8'h90);
			st_r = (a != 16'h5555) ? 3'h0 : (d == 8'hA0) ? 3'h6 : (d == 8'h80) ? 3'h3 : 3'h0;
		end
		3'h5:
		begin
			st_r = 3'h0;
			if (d == 8'h30)
				erase(a[15:9]);
			if (d == 8'h10 && a == 16'h5555)
				chip;
			#SECT_NS;
		end
		default:
		begin
			st_r = 3'h0;
			mem[a] = mem[a] & d;
			#PROG_NS;
		end
		endcase
	endtask
	always @(rd or addr or id_r)
		dq_out = !rd ? ~dq_out : !id_r ? mem[addr] : (addr == 16'h0000) ? MFR_ID
			: (addr == 16'h0001) ? DEV_ID : 8'hFF;
endmodule // pfcs_flash_model

// file: verif/pfcs_host_sva.sv
`timescale 1ns/1ps
module pfcs_host_sva (
	input wire        clk,
	input wire        rst,
	input wire        req_valid,
	input wire        req_ready,
	input wire [15:0] flash_addr,
	input wire        flash_ce_n,
	input wire        flash_oe_n,
	input wire        flash_we_n,
	input wire [7:0]  flash_dq_o,
	input wire        flash_dq_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_strobe;
		(!flash_we_n) [*3] ##1 flash_we_n;
	endsequence
	sequence s_hold;
		(!flash_ce_n && flash_dq_oe && $stable(flash_dq_o)) ##1 !flash_ce_n ##[1:2] flash_ce_n;
	endsequence
	a_we_strobe: assert property ($fell(flash_we_n) |-> s_strobe) else $error("strobe width");
	a_addr_setup: assert property ($fell(flash_we_n) |-> $stable(flash_addr)
		&& $stable(flash_dq_o) && !$past(flash_ce_n)) else $error("setup");
	a_data_hold: assert property ($rose(flash_we_n) |-> s_hold) else $error("data hold");
	a_addr_held: assert property (!flash_we_n |=> flash_we_n || $stable(flash_addr))
		else $error("addr moved");
	a_write_inhibit: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe)
		else $error("write form");
	a_read_form: assert property (!flash_oe_n |-> !flash_ce_n && flash_we_n && !flash_dq_oe)
		else $error("read form");
	a_idle_bus: assert property (req_ready |-> flash_ce_n && !flash_dq_oe)
		else $error("idle bus");
	a_one_at_time: assert property (req_valid && req_ready |=> !req_ready)
		else $error("busy");
endmodule // pfcs_host_sva
bind pfcs_host pfcs_host_sva pfcs_host_sva_i (.clk(clk), .rst(rst), .req_valid(req_valid),
	.req_ready(req_ready), .flash_addr(flash_addr), .flash_ce_n(flash_ce_n),
	.flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_dq_o(flash_dq_o),
	.flash_dq_oe(flash_dq_oe));

// file: verif/pfcs_host_bench.sv
`timescale 1ns/1ps
module pfcs_host_bench;
	localparam  MFR = 8'h5A; // arbitrary
	localparam  DEV = 8'hC3; // arbitrary
	reg         clk = 1'b0;
	reg         rst = 1'b1;
	reg         rv = 1'b0;
	reg  [2:0]  ro = 3'h0;
	reg  [15:0] ra = 16'h0000;
	reg  [7:0]  rd = 8'h00;
	wire        rdy;
	wire        rsp;
	wire [7:0]  d1;
	wire [7:0]  d2;
	wire [15:0] fa;
	wire        fce;
	wire        foe;
	wire        fwe;
	wire [7:0]  fdo;
	wire        foen;
	wire [7:0]  mdq;
	wire [7:0]  dq = foen ? fdo : mdq;
	reg  [7:0]  got;
	reg  [7:0]  got2;
	integer     n_fail = 0;
	integer     cmp_count = 0;
	integer     k;
	always #20 clk = ~clk;
	pfcs_host #(.PROG_CYC(20), .SECTOR_CYC(50), .CHIP_CYC(100)) pfcs_host_i (.clk(clk),
		.rst(rst), .req_valid(rv), .req_ready(rdy), .req_op(ro), .req_addr(ra),
		.req_data(rd), .rsp_valid(rsp), .rsp_data(d1), .rsp_data2(d2), .flash_addr(fa),
		.flash_ce_n(fce), .flash_oe_n(foe), .flash_we_n(fwe), .flash_dq_o(fdo),
		.flash_dq_oe(foen), .flash_dq_i(dq));
	pfcs_flash_model #(.MFR_ID(MFR), .DEV_ID(DEV)) flash_i (.addr(fa), .ce_n(fce),
		.oe_n(foe), .we_n(fwe), .dq_in(dq), .dq_out(mdq));
	task give_verdict;
	begin
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask
	task chk(input [95:0] nm, input [7:0] exp, input [7:0] seen);
	begin
		cmp_count = cmp_count + 1;
		if (seen !== exp)
		begin
			n_fail = n_fail + 1;
			$display("MISMATCH %0s exp %h seen %h", nm, exp, seen);
		end
	end
	endtask
	// one request, bounded waits for take and for the answer pulse
	task op(input [2:0] o, input [15:0] a, input [7:0] d);
	begin
		ro = o;
		ra = a;
		rd = d;
		rv = 1'b1;
		k = 0;
		while (rdy !== 1'b1 && k < 100)
		begin
			@(posedge clk);
			#1 k = k + 1;
		end
		@(posedge clk);
		#1 rv = 1'b0;
		while (rsp !== 1'b1 && k < 9000)
		begin
			@(posedge clk);
			#1 k = k + 1;
		end
		got = d1;
		got2 = d2;
		if (k >= 9000)
		begin
			n_fail = n_fail + 1;
			give_verdict;
		end
	end
	endtask
	task t_fresh;
	begin
		op(3'h0, 16'h1234, 8'h00);
		chk("fresh", 8'hFF, got);
	end
	endtask
	task t_prog;
	begin
		op(3'h1, 16'h0203, 8'h5A);
		op(3'h1, 16'h0400, 8'h3C);
		op(3'h0, 16'h0203, 8'h00);
		chk("prog", 8'h5A, got);
	end
	endtask
	task t_ident;
	begin
		op(3'h6, 16'h0000, 8'h00);
		chk("mfr", MFR, got);
		chk("dev", DEV, got2);
		op(3'h5, 16'h0000, 8'h00);
		op(3'h0, 16'h0203, 8'h00);
		chk("rst_long", 8'h5A, got);
		op(3'h6, 16'h0000, 8'h00);
		op(3'h4, 16'h7777, 8'h00);
		op(3'h0, 16'h0400, 8'h00);
		chk("rst_short", 8'h3C, got);
	end
	endtask
	task t_sect;
	begin
		op(3'h2, 16'h0210, 8'h00);
		op(3'h0, 16'h0203, 8'h00);
		chk("erased", 8'hFF, got);
		op(3'h0, 16'h0400, 8'h00);
		chk("kept", 8'h3C, got);
		op(3'h1, 16'h0203, 8'h11);
		op(3'h0, 16'h0203, 8'h00);
		chk("reprog", 8'h11, got);
	end
	endtask
	task t_chip;
	begin
		op(3'h7, 16'h0000, 8'h00);
		op(3'h3, 16'h0000, 8'h00);
		op(3'h0, 16'h0400, 8'h00);
		chk("chip_a", 8'hFF, got);
		op(3'h0, 16'h0203, 8'h00);
		chk("chip_b", 8'hFF, got);
	end
	endtask
	initial
	begin
		repeat (10) @(posedge clk);
		#1 rst = 1'b0;
		t_fresh;
		t_prog;
		t_ident;
		t_sect;
		t_chip;
		give_verdict;
	end
endmodule // pfcs_host_bench
